// ===== vifu_pkg.sv
package vifu_pkg;
  // register addresses on the special function register port
  localparam logic [15:0] IF_ADDR = 16'hffe0;
  localparam logic [15:0] MK_ADDR = 16'hffe4;
  localparam logic [15:0] EDGE_ADDR = 16'hffec;
  // values after reset
  localparam logic [7:0] IF_RESET = 8'h00;
  localparam logic [7:0] MK_RESET = 8'hff;
  localparam logic [7:0] EDGE_RESET = 8'h00;
  // bits of the edge select register that can be written
  localparam logic [7:0] EDGE_WMASK = 8'h3c;
  localparam int EDGE_PIN0_LSB = 2;
  localparam int EDGE_PIN1_LSB = 4;
  // edge select codes
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BAD = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // flag positions, priority 1 at bit 1 down to priority 7 at bit 7
  localparam int SRC_LOW_VOLTAGE = 1;
  localparam int SRC_EXT_PIN0 = 2;
  localparam int SRC_EXT_PIN1 = 3;
  localparam int SRC_TIMER_H = 4;
  localparam int SRC_TIMER16_CH0 = 5;
  localparam int SRC_TIMER16_CH1 = 6;
  localparam int SRC_CONVERSION = 7;
  // vectors: entry of source n sits at VEC_BASE + 2*n
  localparam logic [15:0] VEC_BASE = 16'h0004;
  localparam logic [15:0] RESET_VEC = 16'h0000;
endpackage

// ===== vifu_irq_unit.sv
//Contract
//RULE1: two kinds only: maskable requests and non-maskable resets.
//RULE2: any raised maskable request asserts standby release, acknowledgeable or not; the code releases only on unmasked requests.
//RULE3: acknowledged request sends the CPU to that source's vector entry.
//RULE4: simultaneous requests served by fixed priority, 1 highest, 7 lowest.
//RULE5: low-voltage gives priority 1 at 0006H, or reset when detector mode bit is 1.
//RULE6: pin 0 edge gives priority 2 at 0008H, pin 1 edge priority 3 at 000AH.
//RULE7: timer H compare match gives priority 4 at 000CH.
//RULE8: priority 5 at 000EH: channel 0 match, or capture pin 1 edge in capture mode.
//RULE9: priority 6 at 0010H: channel 1 match, or capture pin 0 edge in capture mode.
//RULE10: conversion done gives priority 7 at 0012H, only in converter variant.
//RULE11: reset pin, power-on clear, low-voltage reset mode, watchdog all vector 0000H.
//RULE12: any reset restores registers, then execution starts at vector 0000H.
//RULE13: request flag set by its source or by software writing 1.
//RULE14: request flag cleared by acknowledge, software clear, or reset.
//RULE15: request flag register takes single-bit and whole-byte writes.
//RULE16: request flag register resets to 00H.
//RULE17: flag 0 means nothing pending, 1 means request awaits service.
//RULE18: software masks a shared pin before using it as a port output.
//RULE19: seven sources with converter, six without.
//RULE20: each source owns one request flag and one mask flag.
//RULE21: acknowledge only when flag is 1, mask is 0 and global enable is 1.
//RULE22: mask flag register resets to FFH, all sources disabled.
//RULE23: two-bit edge select per pin: falling, rising, both; one code prohibited.
//RULE24: on acknowledge CPU saves status and PC, global enable cleared, PC from vector.
//RULE25: request bit 0 reads 0; bits 1 to 7 hold sources in priority order.
//RULE26: priority and vector resolved on the clock from registered flags and masks.
`timescale 1ns/10ps
module vifu_irq_unit
  import vifu_pkg::*;
#(
  parameter bit HAS_CONVERTER = 1'b1
)(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_bit_i,
  input wire logic [2:0] sfr_bitsel_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic low_voltage_i,
  input wire logic detector_mode_bit_i,
  input wire logic ext_pin0_i,
  input wire logic ext_pin1_i,
  input wire logic timer_h_match_i,
  input wire logic timer16_ch0_match_i,
  input wire logic timer16_ch1_match_i,
  input wire logic timer16_ch0_capture_mode_i,
  input wire logic timer16_ch1_capture_mode_i,
  input wire logic capture_input_pin0_edge_i,
  input wire logic capture_input_pin1_edge_i,
  input wire logic conversion_done_i,
  input wire logic ext_reset_i,
  input wire logic power_on_clear_i,
  input wire logic watchdog_overflow_i,
  input wire logic global_irq_enable_i,
  input wire logic cpu_boundary_i,
  output logic irq_ack_o,
  output logic ie_clear_o,
  output logic [15:0] vector_o,
  output logic standby_release_o,
  output logic sys_reset_o
);

  // lowest set index wins, so priority 1 beats priority 7
  function automatic logic [2:0] prio_pick(input logic [7:0] req);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 1; i--)
    begin
      if (req[i])
      begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    logic hit;
    unique case (sel)
      EDGE_FALL: hit = prev & ~cur;
      EDGE_RISE: hit = ~prev & cur;
      EDGE_BOTH: hit = prev ^ cur;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  logic [7:0] if_r, if_nxt;
  logic [7:0] mk_r, mk_nxt;
  logic [7:0] edge_r, edge_nxt;
  logic pin0_r, pin0_nxt;
  logic pin1_r, pin1_nxt;
  logic ack_r, ack_nxt;
  logic [15:0] vec_r, vec_nxt;
  logic stb_r, stb_nxt;
  logic rst_req_r, rst_req_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] src;
  logic [7:0] live_mask;
  logic [7:0] enabled;
  logic reset_src;
  logic wipe;
  logic acc_if, acc_mk, acc_edge;
  logic take;
  logic [2:0] win;

  assign live_mask = HAS_CONVERTER ? 8'hfe : 8'h7e; //RULE19 RULE25
  assign reset_src = ext_reset_i | power_on_clear_i | watchdog_overflow_i
                   | (low_voltage_i & detector_mode_bit_i); //RULE11 RULE5 RULE1
  // a reset request also clears every register except rst_req_r for its own cycle
  assign wipe = rst_i | rst_req_r; //RULE12
  assign acc_if = (sfr_wr_i | sfr_rd_i) && sfr_addr_i == IF_ADDR;
  assign acc_mk = (sfr_wr_i | sfr_rd_i) && sfr_addr_i == MK_ADDR;
  assign acc_edge = sfr_wr_i && sfr_addr_i == EDGE_ADDR;
  assign enabled = if_r & ~mk_r & live_mask; //RULE20 RULE26
  assign win = prio_pick(enabled); //RULE4
  // requests wait while their own registers are being touched
  assign take = global_irq_enable_i && cpu_boundary_i && (|enabled)
              && !ack_r && !acc_if && !acc_mk; //RULE21

  always_comb
  begin
    src = 8'h00;
    src[SRC_LOW_VOLTAGE] = low_voltage_i & ~detector_mode_bit_i; //RULE5
    src[SRC_EXT_PIN0] = edge_hit(edge_r[EDGE_PIN0_LSB +: 2], pin0_r, ext_pin0_i); //RULE6
    src[SRC_EXT_PIN1] = edge_hit(edge_r[EDGE_PIN1_LSB +: 2], pin1_r, ext_pin1_i); //RULE6
    src[SRC_TIMER_H] = timer_h_match_i; //RULE7
    src[SRC_TIMER16_CH0] = timer16_ch0_capture_mode_i ? capture_input_pin1_edge_i
                                                      : timer16_ch0_match_i; //RULE8
    src[SRC_TIMER16_CH1] = timer16_ch1_capture_mode_i ? capture_input_pin0_edge_i
                                                      : timer16_ch1_match_i; //RULE9
    src[SRC_CONVERSION] = conversion_done_i & HAS_CONVERTER; //RULE10
  end

  // flags and registers
  always_comb
  begin
    if_nxt = if_r;
    mk_nxt = mk_r;
    edge_nxt = edge_r;
    if (take)
    begin
      if_nxt[win] = 1'b0; //RULE14
    end
    if (sfr_wr_i && sfr_addr_i == IF_ADDR)
    begin
      if (sfr_bit_i)
      begin
        if_nxt[sfr_bitsel_i] = sfr_wdata_i[0]; //RULE15 RULE13
      end
      else
      begin
        if_nxt = sfr_wdata_i; //RULE15
      end
    end
    if (sfr_wr_i && sfr_addr_i == MK_ADDR)
    begin
      if (sfr_bit_i)
      begin
        mk_nxt[sfr_bitsel_i] = sfr_wdata_i[0];
      end
      else
      begin
        mk_nxt = sfr_wdata_i;
      end
    end
    if (acc_edge)
    begin
      // bit writes are not decoded: every write loads the whole masked byte
      edge_nxt = sfr_wdata_i & EDGE_WMASK; //RULE23
    end
    // a source event in the clearing cycle is kept: set beats clear
    if_nxt = (if_nxt | src) & live_mask; //RULE13 RULE17
    mk_nxt = mk_nxt | ~live_mask;
    pin0_nxt = ext_pin0_i;
    pin1_nxt = ext_pin1_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (wipe)
    begin
      if_r <= IF_RESET; //RULE16 RULE14
      mk_r <= MK_RESET; //RULE22
      edge_r <= EDGE_RESET;
      pin0_r <= 1'b0;
      pin1_r <= 1'b0;
    end
    else
    begin
      if_r <= if_nxt;
      mk_r <= mk_nxt;
      edge_r <= edge_nxt;
      pin0_r <= pin0_nxt;
      pin1_r <= pin1_nxt;
    end
  end

  // acknowledge, vector, standby release, read data
  always_comb
  begin
    ack_nxt = take;
    vec_nxt = vec_r;
    if (take)
    begin
      vec_nxt = VEC_BASE + {12'h000, win, 1'b0}; //RULE3 RULE24
    end
    stb_nxt = |(if_nxt & ~mk_nxt); //RULE2
    rst_req_nxt = reset_src;
    rdata_nxt = rdata_r;
    if (sfr_rd_i)
    begin
      unique case (sfr_addr_i)
        IF_ADDR: rdata_nxt = if_r;
        MK_ADDR: rdata_nxt = mk_r;
        EDGE_ADDR: rdata_nxt = edge_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rst_req_r <= 1'b0;
    end
    else
    begin
      rst_req_r <= rst_req_nxt; //RULE11
    end
    if (wipe)
    begin
      ack_r <= 1'b0;
      vec_r <= RESET_VEC; //RULE12
      stb_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      ack_r <= ack_nxt;
      vec_r <= vec_nxt;
      stb_r <= stb_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign irq_ack_o = ack_r;
  assign ie_clear_o = ack_r; //RULE24
  assign vector_o = vec_r;
  assign standby_release_o = stb_r;
  assign sys_reset_o = rst_req_r;
  assign sfr_rdata_o = rdata_r;

  // checks
  property p_flag_reset;
    @(posedge clk_i) rst_i |=> if_r == IF_RESET && mk_r == MK_RESET;
  endproperty
  a_flag_reset: assert property (p_flag_reset) else $error("flags not reset"); //RULE16

  property p_mask_blocks;
    @(posedge clk_i) disable iff (rst_i)
      irq_ack_o |-> $past(if_r[win] && !mk_r[win]);
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("masked ack"); //RULE21

  property p_ie_needed;
    @(posedge clk_i) disable iff (wipe) irq_ack_o |-> $past(global_irq_enable_i);
  endproperty
  a_ie_needed: assert property (p_ie_needed) else $error("ack without enable"); //RULE21

  property p_vector_range;
    @(posedge clk_i) disable iff (wipe)
      irq_ack_o |-> vector_o >= 16'h0006 && vector_o <= 16'h0012 && !vector_o[0];
  endproperty
  a_vector_range: assert property (p_vector_range) else $error("bad vector"); //RULE3

  property p_prio_top;
    @(posedge clk_i) disable iff (wipe)
      (take && enabled[SRC_LOW_VOLTAGE]) |=> vector_o == 16'h0006;
  endproperty
  a_prio_top: assert property (p_prio_top) else $error("priority 1 lost"); //RULE4

  property p_ack_clears;
    @(posedge clk_i) disable iff (wipe)
      (take && !src[win] && !(sfr_wr_i && sfr_addr_i == IF_ADDR)) |=> !if_r[$past(win)];
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("flag not cleared"); //RULE14

  property p_src_sets;
    @(posedge clk_i) disable iff (wipe) src[SRC_TIMER_H] |=> if_r[SRC_TIMER_H];
  endproperty
  a_src_sets: assert property (p_src_sets) else $error("flag not set"); //RULE13

  property p_standby;
    @(posedge clk_i) disable iff (wipe)
      (|(if_r & ~mk_r)) |-> standby_release_o;
  endproperty
  a_standby: assert property (p_standby) else $error("no standby release"); //RULE2

  property p_reset_src;
    @(posedge clk_i) disable iff (rst_i)
      watchdog_overflow_i |=> sys_reset_o ##1 (if_r == IF_RESET && vector_o == RESET_VEC);
  endproperty
  a_reset_src: assert property (p_reset_src) else $error("reset source ignored"); //RULE11

  property p_bit0_zero;
    @(posedge clk_i) disable iff (rst_i) !if_r[0] && mk_r[0];
  endproperty
  a_bit0_zero: assert property (p_bit0_zero) else $error("bit 0 live"); //RULE25

  property p_ack_single;
    @(posedge clk_i) disable iff (wipe) irq_ack_o |=> !irq_ack_o;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("ack too long"); //RULE4

  property p_ie_clear_pair;
    @(posedge clk_i) disable iff (wipe) ie_clear_o == irq_ack_o;
  endproperty
  a_ie_clear_pair: assert property (p_ie_clear_pair) else $error("ie clear apart"); //RULE24

  property p_lv_reset;
    @(posedge clk_i) disable iff (rst_i) (low_voltage_i && detector_mode_bit_i) |=> sys_reset_o;
  endproperty
  a_lv_reset: assert property (p_lv_reset) else $error("low voltage reset lost"); //RULE5

  property p_edge_bad;
    @(posedge clk_i) (edge_r[EDGE_PIN0_LSB +: 2] == EDGE_BAD) |-> !src[SRC_EXT_PIN0];
  endproperty
  a_edge_bad: assert property (p_edge_bad) else $error("prohibited edge code fired"); //RULE23

  property p_hold_access;
    @(posedge clk_i) disable iff (wipe) (acc_if || acc_mk) |=> !irq_ack_o;
  endproperty
  a_hold_access: assert property (p_hold_access) else $error("ack during access"); //RULE21

  property p_vec_hold;
    @(posedge clk_i) disable iff (wipe) !take |=> $stable(vector_o);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved"); //RULE3
endmodule

// ===== vifu_cpu_model.sv
`timescale 1ns/10ps
module vifu_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ei_i,
  input wire logic slow_i,
  input wire logic ie_clear_i,
  output logic global_irq_enable_o,
  output logic cpu_boundary_o
);
  logic [1:0] phase_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      global_irq_enable_o <= 1'b0;
      phase_r <= 2'h0;
    end
    else
    begin
      phase_r <= phase_r + 2'h1;
      if (ie_clear_i)
        global_irq_enable_o <= 1'b0;
      else if (ei_i)
        global_irq_enable_o <= 1'b1;
    end
  end
  // a slow core reaches a boundary one cycle in four, so requests wait pending
  assign cpu_boundary_o = !slow_i || (phase_r == 2'h3);
endmodule

// ===== vifu_irq_unit_tb.sv
`timescale 1ns/10ps
module vifu_irq_unit_tb;
  import vifu_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic [15:0] addr = 16'h0000;
  logic wr = 0, bsel = 0, rd = 0, p0 = 1, p1 = 1, lvm = 0, ei = 0, slow = 0;
  logic [2:0] bidx = 3'h0, rs = 3'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [7:1] ev = 7'h00;
  logic [1:0] cap = 2'h0, cm = 2'h0;
  logic ie, bnd, ack, iec, stby, sres;
  logic [15:0] vec;
  int n_errors = 0;
  int n_checks = 0;
  vifu_irq_unit vifu_irq_unit_i (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(addr),
    .sfr_wr_i(wr), .sfr_bit_i(bsel), .sfr_bitsel_i(bidx), .sfr_wdata_i(wdata),
    .sfr_rd_i(rd), .sfr_rdata_o(rdata), .low_voltage_i(ev[1]),
    .detector_mode_bit_i(lvm), .ext_pin0_i(p0), .ext_pin1_i(p1),
    .timer_h_match_i(ev[4]), .timer16_ch0_match_i(ev[5]), .timer16_ch1_match_i(ev[6]),
    .timer16_ch0_capture_mode_i(cm[0]), .timer16_ch1_capture_mode_i(cm[1]),
    .capture_input_pin0_edge_i(cap[0]), .capture_input_pin1_edge_i(cap[1]),
    .conversion_done_i(ev[7]), .ext_reset_i(rs[0]), .power_on_clear_i(rs[1]),
    .watchdog_overflow_i(rs[2]), .global_irq_enable_i(ie), .cpu_boundary_i(bnd),
    .irq_ack_o(ack), .ie_clear_o(iec), .vector_o(vec), .standby_release_o(stby),
    .sys_reset_o(sres));
  vifu_cpu_model vifu_cpu_model_i (.clk_i(clk_i), .rst_i(rst_i), .ei_i(ei), .slow_i(slow),
    .ie_clear_i(iec), .global_irq_enable_o(ie), .cpu_boundary_o(bnd));
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [15:0] a, input logic [7:0] d, input logic b,
    input logic [2:0] i);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    bsel <= b;
    bidx <= i;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask
  task automatic pulse(input logic [7:1] e, input logic [2:0] r);
    @(posedge clk_i);
    ev <= e;
    rs <= r;
    @(posedge clk_i);
    ev <= 7'h00;
    rs <= 3'h0;
    #1;
  endtask
  task automatic wait_ack(input logic [15:0] e);
    for (int k = 0; k < 20; k++)
    begin
      @(posedge clk_i);
      #1;
      if (ack === 1'b1)
        break;
    end
    chk("ack", 16'h0001, {15'h0, ack});
    chk("ie_clear", 16'h0001, {15'h0, iec});
    chk("vector", e, vec);
  endtask
  initial
  begin
    #20000;
    n_errors++;
    close_out();
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(IF_ADDR, 8'h00);
    rchk(MK_ADDR, 8'hff);
    rchk(EDGE_ADDR, 8'h00);
    rchk(16'hffe2, 8'h00);
    wreg(EDGE_ADDR, 8'hff, 1'b0, 3'h0);
    rchk(EDGE_ADDR, 8'h3c);
    wreg(EDGE_ADDR, 8'h00, 1'b0, 3'h0);
    wreg(IF_ADDR, 8'hff, 1'b0, 3'h0);
    rchk(IF_ADDR, 8'hfe);
    wreg(IF_ADDR, 8'h00, 1'b1, 3'h4);
    rchk(IF_ADDR, 8'hee);
    wreg(IF_ADDR, 8'h00, 1'b0, 3'h0);
    pulse(7'h08, 3'h0);
    rchk(IF_ADDR, 8'h10);
    chk("standby", 16'h0000, {15'h0, stby});
    wreg(MK_ADDR, 8'hef, 1'b0, 3'h0);
    @(posedge clk_i);
    #1;
    chk("standby", 16'h0001, {15'h0, stby});
    chk("ack", 16'h0000, {15'h0, ack});
    // pins only move while every source is masked
    wreg(MK_ADDR, 8'hff, 1'b0, 3'h0);
    @(posedge clk_i);
    ev <= 7'h79;
    p0 <= 1'b0;
    p1 <= 1'b0;
    @(posedge clk_i);
    ev <= 7'h00;
    rchk(IF_ADDR, 8'hfe);
    wreg(MK_ADDR, 8'h01, 1'b0, 3'h0);
    for (int i = 1; i <= 7; i++)
    begin
      @(posedge clk_i);
      ei <= 1'b1;
      slow <= (i > 3);
      @(posedge clk_i);
      ei <= 1'b0;
      wait_ack(VEC_BASE + 16'(2 * i));
    end
    rchk(IF_ADDR, 8'h00);
    wreg(MK_ADDR, 8'hff, 1'b0, 3'h0);
    wreg(EDGE_ADDR, 8'h34, 1'b0, 3'h0);
    @(posedge clk_i);
    p0 <= 1'b1;
    p1 <= 1'b1;
    rchk(IF_ADDR, 8'h0c);
    wreg(IF_ADDR, 8'h00, 1'b0, 3'h0);
    @(posedge clk_i);
    p0 <= 1'b0;
    p1 <= 1'b0;
    rchk(IF_ADDR, 8'h08);
    wreg(EDGE_ADDR, 8'h08, 1'b0, 3'h0);
    wreg(IF_ADDR, 8'h00, 1'b0, 3'h0);
    @(posedge clk_i);
    p0 <= 1'b1;
    p1 <= 1'b1;
    rchk(IF_ADDR, 8'h00);
    @(posedge clk_i);
    cm <= 2'h3;
    cap <= 2'h2;
    ev <= 7'h30;
    @(posedge clk_i);
    cap <= 2'h0;
    ev <= 7'h00;
    rchk(IF_ADDR, 8'h20);
    @(posedge clk_i);
    cap <= 2'h1;
    @(posedge clk_i);
    cap <= 2'h0;
    rchk(IF_ADDR, 8'h60);
    wreg(MK_ADDR, 8'h00, 1'b0, 3'h0);
    lvm <= 1'b1;
    pulse(7'h01, 3'h0);
    chk("sys_reset", 16'h0001, {15'h0, sres});
    @(posedge clk_i);
    #1;
    chk("vector", RESET_VEC, vec);
    rchk(MK_ADDR, 8'hff);
    rchk(IF_ADDR, 8'h00);
    for (int j = 0; j < 3; j++)
    begin
      wreg(MK_ADDR, 8'h00, 1'b0, 3'h0);
      pulse(7'h00, 3'(1 << j));
      chk("sys_reset", 16'h0001, {15'h0, sres});
      rchk(MK_ADDR, 8'hff);
    end
    close_out();
  end
endmodule
